/* File: pfb_flash_model.sv */
`timescale 1ns/1ns
`default_nettype none
module pfb_flash_model #(
    parameter int ACC_NS = 80,
    parameter int BUSY_NS = 2000,
    // Arbitrary value.
    parameter logic [7:0] ID_CODE = 8'h5A
) (
    // Flash pins; bus is the resolved data wire.
    input wire logic [19:0] word_addr,
    input wire logic chip_select_n,
    input wire logic output_enable_n,
    input wire logic write_strobe_n,
    input wire logic width_select_n,
    input wire logic hw_reset_n,
    input wire logic [15:0] bus,
    output logic [15:0] dev,
    output logic ready_busy_n
);
    logic [19:0] pa = 20'hFFFFF;
    logic [15:0] pd, w;
    logic [7:0] rd;
    logic ident = 1'h0, armed = 1'h0, busy = 1'h0, wide, on;
    time t_chg = 0;
    initial dev = 16'h0000;
    assign ready_busy_n = !busy;
    always @(word_addr, chip_select_n, output_enable_n) t_chg = $time;
    always @(negedge hw_reset_n) {ident, armed, busy} = 3'h0;
    // Latched just after the fall, since the host starts driving data on the same edge.
    always @(negedge write_strobe_n) begin
        #1;
        if (!chip_select_n && output_enable_n && hw_reset_n && armed) begin
            // Byte programming keeps only the low byte of the bus.
            {pa, pd, armed, busy} = {word_addr, width_select_n ? bus : {8'hFF, bus[7:0]}, 2'h1};
            busy <= #(BUSY_NS) 1'h0;
        end else if (!chip_select_n && output_enable_n && hw_reset_n && bus[7:0] == 8'h30) begin
            // A sector erase blanks the stored word when it lies in the addressed sector.
            if (word_addr[19:12] == pa[19:12]) begin
                pd = 16'hFFFF;
            end
            {ident, busy} = 2'h1;
            busy <= #(BUSY_NS) 1'h0;
        end else if (!chip_select_n && output_enable_n && hw_reset_n) begin
            {ident, armed} = {bus[7:0] == 8'h90, bus[7:0] == 8'hA0};
        end
    end
    // Undriven pins flip every nanosecond, so stale data never reads as valid.
    always #1 begin
        w = word_addr == pa ? pd : {12'hA50, word_addr[3:0]};
        wide = width_select_n && !busy && !ident;
        rd = busy ? {~pd[7], 7'h0} : ident ? ID_CODE :
            (width_select_n || !bus[15]) ? w[7:0] : w[15:8];
        on = hw_reset_n && !chip_select_n && !output_enable_n && $time - t_chg >= ACC_NS;
        dev = on ? {wide ? w[15:8] : ~dev[15:8], rd} : ~dev;
    end
endmodule
`default_nettype wire

/* File: pfb_host.sv */
// Overview of operation
// - Read with select and output low, write high.
// - Write with select and write low, output high.
// - Bypass programming needs two writes, not four.
// - Protect: high voltage, select, write, address bits.
`timescale 1ns/1ns
`default_nettype none
module pfb_host #(
    parameter int ADDR_W = pfb_pkg::ADDR_W,
    parameter int DATA_W = pfb_pkg::DATA_W,
    parameter int ACCESS_CYC = pfb_pkg::ACCESS_CYC,
    parameter int RECOVER_CYC = pfb_pkg::RECOVER_CYC
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic reset,
    // Software register port.
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Device address and control pins.
    output logic [ADDR_W-1:0] word_addr,
    output logic chip_select_n,
    output logic output_enable_n,
    output logic write_strobe_n,
    output logic width_select_n,
    output logic hw_reset_n,
    output logic high_voltage_level,
    // Device data pins, low fifteen bits.
    input wire logic [DATA_W-2:0] data_io_in,
    output logic [DATA_W-2:0] data_io_out,
    output logic [DATA_W-2:0] data_io_oe,
    // Top data pin, or byte address in byte mode.
    input wire logic top_data_or_byte_addr_in,
    output logic top_data_or_byte_addr_out,
    output logic top_data_or_byte_addr_oe,
    // Device ready indication.
    input wire logic ready_busy_n
);
    typedef struct packed {
        pfb_pkg::pfb_state_e state;
        logic [pfb_pkg::CNT_W-1:0] cnt;
        logic [ADDR_W:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic is_write;
        logic byte_mode;
        logic protect;
        logic unprot;
        logic done;
        logic [31:0] rd_out;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic rst_n;
        logic hv;
        logic drive;
    } pfb_reg_s;

    pfb_reg_s cur_ff;
    pfb_reg_s nxt_cur;
    logic [DATA_W-1:0] pins_sync;
    logic rb_sync;

    // Every pin input crosses two flip-flops before use.
    pfb_sync #(.WIDTH(DATA_W + 1)) u_sync (
        .clock(clock),
        .reset(reset),
        .async_in({ready_busy_n, top_data_or_byte_addr_in, data_io_in}),
        .sync_out({rb_sync, pins_sync})
    );

    function automatic logic [pfb_pkg::CNT_W-1:0] to_cnt(input int cycles);
        to_cnt = pfb_pkg::CNT_W'(cycles);
    endfunction

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.rd_out = 32'h0000_0000;
        if (reg_read) begin
            unique case (reg_addr)
                pfb_pkg::REG_ADDR: nxt_cur.rd_out = 32'(cur_ff.addr);
                pfb_pkg::REG_WDATA: nxt_cur.rd_out = {16'h0000, cur_ff.rdata};
                pfb_pkg::REG_STATUS: nxt_cur.rd_out =
                    {29'h0000_0000, rb_sync, cur_ff.done, cur_ff.state != pfb_pkg::PFB_IDLE};
                default: nxt_cur.rd_out = 32'h0000_0000;
            endcase
        end
        unique case (cur_ff.state)
            pfb_pkg::PFB_IDLE: begin
                nxt_cur.ce_n = 1'b1;
                nxt_cur.oe_n = 1'b1;
                nxt_cur.we_n = 1'b1;
                nxt_cur.hv = 1'b0;
                nxt_cur.drive = 1'b0;
                if (reg_write && reg_addr == pfb_pkg::REG_ADDR) begin
                    nxt_cur.addr = reg_wdata[ADDR_W:0];
                end
                if (reg_write && reg_addr == pfb_pkg::REG_WDATA) begin
                    nxt_cur.wdata = reg_wdata[DATA_W-1:0];
                end
                if (reg_write && reg_addr == pfb_pkg::REG_CTRL) begin
                    nxt_cur.byte_mode = reg_wdata[pfb_pkg::CTRL_BYTE];
                    if (reg_wdata[pfb_pkg::CTRL_RESET]) begin
                        // Pulsing the device reset aborts any running operation.
                        nxt_cur.rst_n = 1'b0;
                        nxt_cur.cnt = to_cnt(ACCESS_CYC);
                        nxt_cur.done = 1'b0;
                        nxt_cur.state = pfb_pkg::PFB_RESET;
                    end else if (reg_wdata[pfb_pkg::CTRL_GO]) begin
                        nxt_cur.is_write = reg_wdata[pfb_pkg::CTRL_WRITE];
                        nxt_cur.protect = reg_wdata[pfb_pkg::CTRL_PROTECT];
                        nxt_cur.unprot = reg_wdata[pfb_pkg::CTRL_UNPROT];
                        if (reg_wdata[pfb_pkg::CTRL_PROTECT]
                                | reg_wdata[pfb_pkg::CTRL_UNPROT]) begin
                            // The sector address settles a cycle before any strobe falls.
                            nxt_cur.addr[2] = 1'b1;
                            nxt_cur.addr[1] = 1'b0;
                            nxt_cur.addr[7] = reg_wdata[pfb_pkg::CTRL_UNPROT];
                        end
                        nxt_cur.done = 1'b0;
                        // Extra cycles cover the pin synchroniser, so data is a full access old.
                        nxt_cur.cnt = to_cnt(ACCESS_CYC + pfb_pkg::SYNC_CYC);
                        nxt_cur.state = pfb_pkg::PFB_SETUP;
                    end
                end
            end
            pfb_pkg::PFB_SETUP: begin
                // Address settles one cycle before the strobes fall.
                nxt_cur.ce_n = 1'b0;
                nxt_cur.hv = cur_ff.protect | cur_ff.unprot;
                if (cur_ff.is_write | cur_ff.protect | cur_ff.unprot) begin
                    nxt_cur.we_n = 1'b0;
                    nxt_cur.oe_n = 1'b1;
                    nxt_cur.drive = 1'b1;
                end else begin
                    nxt_cur.oe_n = 1'b0;
                    nxt_cur.we_n = 1'b1;
                end
                nxt_cur.state = pfb_pkg::PFB_STROBE;
            end
            pfb_pkg::PFB_STROBE: begin
                // Strobes stand a full access time before data is taken.
                if (cur_ff.cnt > to_cnt(1)) begin
                    nxt_cur.cnt = cur_ff.cnt - to_cnt(1);
                end else begin
                    if (!cur_ff.is_write) begin
                        nxt_cur.rdata = cur_ff.byte_mode ?
                            {8'h00, pins_sync[7:0]} : pins_sync;
                    end
                    nxt_cur.we_n = 1'b1;
                    nxt_cur.oe_n = 1'b1;
                    nxt_cur.cnt = to_cnt(RECOVER_CYC);
                    nxt_cur.state = pfb_pkg::PFB_RECOVER;
                end
            end
            pfb_pkg::PFB_RECOVER: begin
                // Select drops only after data hold; the device keeps busy work going.
                if (cur_ff.cnt > to_cnt(1)) begin
                    nxt_cur.cnt = cur_ff.cnt - to_cnt(1);
                end else begin
                    nxt_cur.ce_n = 1'b1;
                    nxt_cur.drive = 1'b0;
                    nxt_cur.hv = 1'b0;
                    nxt_cur.done = 1'b1;
                    nxt_cur.state = pfb_pkg::PFB_IDLE;
                end
            end
            pfb_pkg::PFB_RESET: begin
                if (cur_ff.cnt > to_cnt(1)) begin
                    nxt_cur.cnt = cur_ff.cnt - to_cnt(1);
                end else begin
                    nxt_cur.rst_n = 1'b1;
                    nxt_cur.done = 1'b1;
                    nxt_cur.state = pfb_pkg::PFB_IDLE;
                end
            end
            default: nxt_cur.state = pfb_pkg::PFB_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cur_ff <= '{state: pfb_pkg::PFB_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                rst_n: 1'b1, default: '0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign reg_rdata = cur_ff.rd_out;
    assign word_addr = cur_ff.addr[ADDR_W:1];
    assign chip_select_n = cur_ff.ce_n;
    assign output_enable_n = cur_ff.oe_n;
    assign write_strobe_n = cur_ff.we_n;
    assign width_select_n = ~cur_ff.byte_mode;
    assign hw_reset_n = cur_ff.rst_n;
    assign high_voltage_level = cur_ff.hv;
    assign data_io_out = cur_ff.wdata[DATA_W-2:0];
    // In byte mode only the low byte is driven; the top pin carries the byte address.
    assign data_io_oe = cur_ff.byte_mode ? {7'h00, {8{cur_ff.drive}}}
        : {(DATA_W - 1){cur_ff.drive}};
    assign top_data_or_byte_addr_out = cur_ff.byte_mode ? cur_ff.addr[0]
        : cur_ff.wdata[DATA_W-1];
    assign top_data_or_byte_addr_oe = cur_ff.byte_mode | cur_ff.drive;
endmodule
`default_nettype wire

/* File: pfb_host_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module pfb_host_sva #(parameter int ACCESS_CYC = pfb_pkg::ACCESS_CYC) (
    // Host pins under watch.
    input wire logic clock,
    input wire logic reset,
    input wire logic [pfb_pkg::ADDR_W-1:0] word_addr,
    input wire logic chip_select_n,
    input wire logic output_enable_n,
    input wire logic write_strobe_n,
    input wire logic high_voltage_level,
    input wire logic [pfb_pkg::DATA_W-2:0] data_io_oe
);
    localparam int HOLD = ACCESS_CYC + pfb_pkg::SYNC_CYC - 1;
    wire logic idle = output_enable_n && write_strobe_n;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    a_read_levels: assert property (!output_enable_n |->
        !chip_select_n && write_strobe_n && data_io_oe == 15'h0) else $error("bad read levels");
    a_write_levels: assert property (!write_strobe_n |->
        !chip_select_n && output_enable_n && data_io_oe[7:0] == 8'hFF) else $error("bad write");
    a_strobe_time: assert property ($fell(idle) |-> !idle throughout (##HOLD 1'h1))
        else $error("strobe too short");
    a_addr_steady: assert property (!idle && !$past(idle) |-> $stable(word_addr))
        else $error("address moved under strobe");
    a_protect_addr: assert property (high_voltage_level && !write_strobe_n |->
        word_addr[1:0] == 2'h2) else $error("bad protect address");
endmodule
bind pfb_host pfb_host_sva #(.ACCESS_CYC(ACCESS_CYC)) chk_u (.clock(clock), .reset(reset),
    .word_addr(word_addr), .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
    .write_strobe_n(write_strobe_n), .high_voltage_level(high_voltage_level),
    .data_io_oe(data_io_oe));
`default_nettype wire

/* File: pfb_host_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module pfb_host_tb;
    logic clock = 1'h0, reset = 1'h1, reg_write = 1'h0, reg_read = 1'h0, rd_d = 1'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, r;
    logic [19:0] word_addr;
    logic chip_select_n, output_enable_n, write_strobe_n, width_select_n, hw_reset_n;
    logic high_voltage_level, top_data_or_byte_addr_out, top_data_or_byte_addr_oe, ready_busy_n;
    logic [14:0] data_io_out, data_io_oe;
    logic [15:0] dev;
    logic [63:0] note, exp_q[$];
    int error_cnt = 0, comparisons = 0;
    wire logic [15:0] hoe = {top_data_or_byte_addr_oe, data_io_oe};
    wire logic [15:0] bus = (hoe & {top_data_or_byte_addr_out, data_io_out}) | (~hoe & dev);
    wire logic [14:0] data_io_in = bus[14:0];
    wire logic top_data_or_byte_addr_in = bus[15];
    pfb_host dut_u (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .word_addr(word_addr), .chip_select_n(chip_select_n),
        .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
        .width_select_n(width_select_n), .hw_reset_n(hw_reset_n),
        .high_voltage_level(high_voltage_level), .data_io_in(data_io_in),
        .data_io_out(data_io_out), .data_io_oe(data_io_oe),
        .top_data_or_byte_addr_in(top_data_or_byte_addr_in),
        .top_data_or_byte_addr_out(top_data_or_byte_addr_out),
        .top_data_or_byte_addr_oe(top_data_or_byte_addr_oe), .ready_busy_n(ready_busy_n));
    // Data settles just inside the access time, so the sampling edge never races the model.
    pfb_flash_model #(.ACC_NS(pfb_pkg::ACCESS_NS - 1)) dev_u (.word_addr(word_addr),
        .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
        .write_strobe_n(write_strobe_n), .width_select_n(width_select_n),
        .hw_reset_n(hw_reset_n), .bus(bus), .dev(dev), .ready_busy_n(ready_busy_n));
    initial forever #2 clock = ~clock;
    task automatic rq(input logic [1:0] s, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        {reg_write, reg_read, reg_addr, reg_wdata} <= {s, a, d};
        @(posedge clock);
        {reg_write, reg_read} <= 2'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back({e & m, m});
        rq(2'h1, a, 32'h0);
    endtask
    task automatic op(input logic [20:0] a, input logic [31:0] d, input logic [31:0] c);
        rq(2'h2, pfb_pkg::REG_ADDR, {11'h0, a});
        rq(2'h2, pfb_pkg::REG_WDATA, d);
        rq(2'h2, pfb_pkg::REG_CTRL, c);
        repeat (40) @(posedge clock);
    endtask
    task automatic cmp(input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch reg_rdata expected %h seen %h", e, s);
        end
    endtask
    always @(posedge clock) begin
        rd_d <= reg_read;
        if (rd_d) begin
            note = exp_q.pop_front();
            cmp(note[63:32], reg_rdata & note[31:0]);
        end
    end
    task automatic tally_and_finish;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #20000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        r = $urandom(1718);
        repeat (20) @(posedge clock);
        reset <= 1'h0;
        // The ready flag needs two edges to cross the pin synchroniser.
        repeat (2) @(posedge clock);
        rd(pfb_pkg::REG_STATUS, 32'h4, 32'h7);
        rd(4'h2, 32'h0, 32'hFFFFFFFF);
        for (int i = 0; i < 3; i++) begin
            r = $urandom % 8;
            op({r[19:0], 1'h0}, 32'h0, 32'h1);
            rd(pfb_pkg::REG_WDATA, 32'hA500 | r, 32'hFFFF);
        end
        for (int b = 0; b < 2; b++) begin
            op({20'h5, b[0]}, 32'h0, 32'h5);
            rd(pfb_pkg::REG_WDATA, b ? 32'hA5 : 32'h5, 32'hFF);
        end
        r = $urandom;
        op(21'h0, 32'hA0, 32'h3);
        op(21'h12, r & 32'hFFFF, 32'h3);
        rd(pfb_pkg::REG_STATUS, 32'h2, 32'h7);
        op(21'h12, 32'h0, 32'h1);
        rd(pfb_pkg::REG_WDATA, {~r[7], 7'h0}, 32'hFF);
        repeat (600) @(posedge clock);
        op(21'h12, 32'h0, 32'h1);
        rd(pfb_pkg::REG_WDATA, r & 32'hFFFF, 32'hFFFF);
        op(21'h0, 32'h30, 32'h3);
        rd(pfb_pkg::REG_STATUS, 32'h2, 32'h7);
        repeat (600) @(posedge clock);
        op(21'h12, 32'h0, 32'h1);
        rd(pfb_pkg::REG_WDATA, 32'hFFFF, 32'hFFFF);
        op(21'h0, 32'h90, 32'h3);
        op(21'h0, 32'h0, 32'h1);
        rd(pfb_pkg::REG_WDATA, 32'h5A, 32'hFF);
        op(21'h0, 32'h0, 32'h8);
        op(21'h0, 32'h0, 32'h1);
        rd(pfb_pkg::REG_WDATA, 32'hA500, 32'hFFFF);
        op(21'h0, 32'h0, 32'h13);
        op(21'h0, 32'h0, 32'h23);
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* File: pfb_pkg.sv */
`default_nettype none
package pfb_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    // Access time of the slowest speed grade, in ns, and the clock period in ns.
    localparam int ACCESS_NS = 120;
    localparam int CLK_NS = 4;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    // Recovery after a write or read strobe, in ns.
    localparam int RECOVER_NS = 20;
    localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
    // Latency of the two-stage pin synchroniser, in cycles.
    localparam int SYNC_CYC = 2;
    localparam int CNT_W = 8;
    // Software register map of the controller, byte addresses.
    localparam logic [3:0] REG_ADDR = 4'h0;
    localparam logic [3:0] REG_WDATA = 4'h4;
    localparam logic [3:0] REG_CTRL = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hC;
    // Control register bit positions.
    localparam int CTRL_GO = 0;
    localparam int CTRL_WRITE = 1;
    localparam int CTRL_BYTE = 2;
    localparam int CTRL_RESET = 3;
    localparam int CTRL_PROTECT = 4;
    localparam int CTRL_UNPROT = 5;
    localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0000;
    typedef enum logic [2:0] {
        PFB_IDLE = 3'h0,
        PFB_SETUP = 3'h1,
        PFB_STROBE = 3'h3,
        PFB_RECOVER = 3'h2,
        PFB_RESET = 3'h6
    } pfb_state_e;
endpackage
`default_nettype wire

/* File: pfb_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module pfb_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic reset,
    // Asynchronous input and its synchronised copy.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            meta_ff <= '0;
            sync_out <= '0;
        end else begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule
`default_nettype wire
